/* rtl/lfs_pkg.sv */
// Shared encodings, counts, state types and helpers for the LPC field and SYNC ends.
package lfs_pkg;

	// ==========================================================================
	// Field encodings
	localparam logic [3:0] START_TGT = 4'h0;
	localparam logic [3:0] START_BM0 = 4'h2;
	localparam logic [3:0] NIB_ONES  = 4'hF;
	localparam logic [3:0] SYNC_READY = 4'h0;
	localparam logic [3:0] SYNC_SWAIT = 4'h5;
	localparam logic [3:0] SYNC_LWAIT = 4'h6;
	localparam logic [3:0] SYNC_MORE  = 4'h9;
	localparam logic [3:0] SYNC_ERR   = 4'hA;
	localparam logic [3:0] SYNC_RSVD  = 4'h7;
	localparam logic [1:0] CT_IO  = 2'h0;
	localparam logic [1:0] CT_MEM = 2'h1;
	localparam logic [1:0] CT_DMA = 2'h2;
	localparam logic [1:0] CT_RSV = 2'h3;
	localparam logic [1:0] SZ_1   = 2'h0;
	localparam logic [1:0] SZ_2   = 2'h1;
	localparam logic [1:0] SZ_RSV = 2'h2;
	localparam logic [1:0] SZ_4   = 2'h3;
	localparam logic [1:0] SIZE_HI_RSVD = 2'h0;
	localparam logic       CTDIR_LSB    = 1'b0;
	localparam logic [31:0] RD_ALL_ONES = 32'hFFFF_FFFF;

	// ==========================================================================
	// Counts
	localparam logic [3:0] ADDR_NIBS_IO  = 4'h4;
	localparam logic [3:0] ADDR_NIBS_MEM = 4'h8;
	localparam logic [3:0] CHAN_NIBS     = 4'h1;
	localparam logic [3:0] HDR_LAST      = 4'h1;
	localparam logic [3:0] NIB_LAST      = 4'h1;
	localparam logic [3:0] TAR_LAST      = 4'h1;
	localparam logic [3:0] ABORT_LAST    = 4'h3;
	localparam logic [3:0] BM_LWAIT_CLKS = 4'h2;
	localparam logic [2:0] TIMEOUT_LAST  = 3'h3;
	localparam logic [2:0] BYTES_1 = 3'h1;
	localparam logic [2:0] BYTES_2 = 3'h2;
	localparam logic [2:0] BYTES_4 = 3'h4;

	// ==========================================================================
	// Types
	typedef enum logic [2:0] {
		SC_READY, SC_SWAIT, SC_LWAIT, SC_MORE, SC_ERR, SC_NONE, SC_BAD
	} lfs_sync_e;
	typedef enum logic [1:0] {ST_OK = 2'h0, ST_ERR = 2'h1, ST_ABORT = 2'h2} lfs_stat_e;
	typedef enum logic [3:0] {
		H_IDLE = 4'h0, H_START = 4'h1, H_CTDIR = 4'h3, H_HDR = 4'h2, H_SIZE = 4'h6,
		H_WDATA = 4'h7, H_TAR = 4'h5, H_SYNC = 4'h4, H_RDATA = 4'hC, H_TARB = 4'hD,
		H_ABORT = 4'hF, H_BMCT = 4'hE, H_BMSIZE = 4'hA, H_BMSYNC = 4'hB
	} lfs_hstate_e;
	typedef enum logic [3:0] {
		P_IDLE = 4'h0, P_CT = 4'h1, P_HDR = 4'h3, P_SIZE = 4'h2, P_WDATA = 4'h6,
		P_TAR = 4'h7, P_SYNC = 4'h5, P_RDATA = 4'h4, P_TARB = 4'hC, P_BMCT = 4'hD,
		P_BMSIZE = 4'hF, P_BMSYNC = 4'hE
	} lfs_pstate_e;

	// ==========================================================================
	// Helpers
	function automatic logic [3:0] ctdir_nib(input logic [1:0] ct, input logic wr);
		return {ct, wr, CTDIR_LSB};
	endfunction

	function automatic logic [3:0] size_nib(input logic [1:0] sz);
		return {SIZE_HI_RSVD, sz};
	endfunction

	function automatic logic [3:0] hdr_nibs(input logic [1:0] ct);
		return (ct == CT_DMA) ? CHAN_NIBS : ((ct == CT_MEM) ? ADDR_NIBS_MEM : ADDR_NIBS_IO);
	endfunction

	function automatic logic [2:0] size_bytes(input logic [1:0] sz);
		return (sz == SZ_2) ? BYTES_2 : ((sz == SZ_4) ? BYTES_4 : BYTES_1);
	endfunction

	function automatic logic [4:0] nib_pos(input logic [1:0] bidx, input logic half);
		return {bidx, half, 2'h0};
	endfunction

endpackage

/* rtl/lfs_if.sv */
// Interface joining the host end and the peripheral end of the LPC link.
`timescale 1ns/1ps
`default_nettype none

interface lfs_if;
	logic       lframe_n;
	logic [3:0] h_lad;
	logic       h_oe_n;
	logic [3:0] p_lad;
	logic       p_oe_n;
	logic [3:0] lad;

	// The pull-ups keep the nibble at all ones when nobody drives it.
	assign lad = !h_oe_n ? h_lad : (!p_oe_n ? p_lad : lfs_pkg::NIB_ONES);

	modport host (input lad, output lframe_n, h_lad, h_oe_n);
	modport periph (input lad, lframe_n, output p_lad, p_oe_n);
endinterface

`default_nettype wire

/* rtl/lfs_sync_class.sv */
// Classifier for a sampled SYNC nibble.
`timescale 1ns/1ps
`default_nettype none

module lfs_sync_class (
	input  wire logic            [3:0] lad_in,
	input  wire logic                  dma_in,
	output var lfs_pkg::lfs_sync_e     kind_out
);
	always_comb
	begin
		unique case (lad_in)
			lfs_pkg::SYNC_READY: kind_out = lfs_pkg::SC_READY;
			lfs_pkg::SYNC_SWAIT: kind_out = lfs_pkg::SC_SWAIT;
			lfs_pkg::SYNC_LWAIT: kind_out = lfs_pkg::SC_LWAIT;
			lfs_pkg::SYNC_MORE:  kind_out = dma_in ? lfs_pkg::SC_MORE : lfs_pkg::SC_BAD;
			lfs_pkg::SYNC_ERR:   kind_out = lfs_pkg::SC_ERR;
			lfs_pkg::NIB_ONES:   kind_out = lfs_pkg::SC_NONE;
			default:             kind_out = lfs_pkg::SC_BAD;
		endcase
	end
endmodule // lfs_sync_class

`default_nettype wire

/* rtl/lfs_periph.sv */
// Peripheral end: target responder and simple bus master on the LPC link.
`timescale 1ns/1ps
`default_nettype none

module lfs_periph (
	input  wire logic        clk_in,
	input  wire logic        arst_n_in,
	lfs_if.periph            bus,
	input  wire logic        claim_in,
	input  wire logic [3:0]  wait_in,
	input  wire logic        long_wait_in,
	input  wire logic        err_in,
	input  wire logic        more_in,
	input  wire logic        bad_sync_in,
	input  wire logic [31:0] rdata_in,
	input  wire logic        bm_req_in,
	input  wire logic        bm_sel_in,
	input  wire logic [1:0]  bm_ctype_in,
	input  wire logic        bm_write_in,
	input  wire logic [1:0]  bm_size_in,
	output logic             hdr_out,
	output logic [1:0]       ctype_out,
	output logic             write_out,
	output logic [31:0]      addr_out,
	output logic             byte_out,
	output logic [7:0]       wdata_out,
	output logic             abort_out,
	output logic             bm_done_out
);
	typedef struct packed {
		lfs_pkg::lfs_pstate_e st;
		logic [3:0]           cnt;
		logic [1:0]           bidx;
		logic [2:0]           nb;
		logic [1:0]           ct;
		logic                 wr;
		logic                 bm;
		logic                 err;
		logic [31:0]          sh;
		logic [7:0]           wd;
		logic                 hdr;
		logic                 byt;
		logic                 abort;
		logic                 bmdone;
	} lfs_preg_s;

	lfs_preg_s state_reg;
	lfs_preg_s state_next;
	logic      last_byte;

	assign last_byte = (3'(state_reg.bidx) + 3'h1) >= state_reg.nb;

	// ==========================================================================
	// Pin drive
	always_comb
	begin
		bus.p_oe_n = 1'b1;
		bus.p_lad  = lfs_pkg::NIB_ONES;
		unique case (state_reg.st)
			lfs_pkg::P_SYNC:
			begin
				bus.p_oe_n = !claim_in;
				if (state_reg.cnt != 4'h0)
					bus.p_lad = long_wait_in ? lfs_pkg::SYNC_LWAIT : lfs_pkg::SYNC_SWAIT;
				else if (bad_sync_in)
					bus.p_lad = lfs_pkg::SYNC_RSVD;
				else if (err_in)
					bus.p_lad = lfs_pkg::SYNC_ERR;
				else if (state_reg.ct == lfs_pkg::CT_DMA && more_in && last_byte)
					bus.p_lad = lfs_pkg::SYNC_MORE;
				else
					bus.p_lad = lfs_pkg::SYNC_READY;
			end
			lfs_pkg::P_RDATA:
			begin
				// Data follows even an error SYNC on a read.
				bus.p_oe_n = 1'b0;
				bus.p_lad  = rdata_in[lfs_pkg::nib_pos(state_reg.bidx, state_reg.cnt[0]) +: 4];
			end
			lfs_pkg::P_BMCT:
			begin
				bus.p_oe_n = 1'b0;
				bus.p_lad  = lfs_pkg::ctdir_nib(bm_ctype_in, bm_write_in);
			end
			lfs_pkg::P_BMSIZE:
			begin
				bus.p_oe_n = 1'b0;
				bus.p_lad  = lfs_pkg::size_nib(bm_size_in);
			end
			default:
			begin
			end
		endcase
	end

	// ==========================================================================
	// Cycle tracking
	always_comb
	begin
		state_next        = state_reg;
		state_next.hdr    = 1'b0;
		state_next.byt    = 1'b0;
		state_next.abort  = 1'b0;
		state_next.bmdone = 1'b0;
		if (!bus.lframe_n && state_reg.st != lfs_pkg::P_IDLE)
		begin
			state_next.st    = lfs_pkg::P_IDLE;
			state_next.abort = 1'b1;
		end
		else
		begin
			unique case (state_reg.st)
				lfs_pkg::P_IDLE:
				begin
					state_next.bidx = 2'h0;
					state_next.err  = 1'b0;
					if (!bus.lframe_n && bus.lad == lfs_pkg::START_TGT)
					begin
						state_next.st = lfs_pkg::P_CT;
						state_next.bm = 1'b0;
					end
					else if (!bus.lframe_n && bm_req_in
						&& bus.lad == (lfs_pkg::START_BM0 | {3'h0, bm_sel_in}))
					begin
						state_next.st = lfs_pkg::P_BMCT;
						state_next.bm = 1'b1;
					end
				end
				lfs_pkg::P_CT:
				begin
					state_next.ct  = bus.lad[3:2];
					state_next.wr  = bus.lad[1];
					state_next.cnt = lfs_pkg::hdr_nibs(bus.lad[3:2]);
					state_next.nb  = lfs_pkg::BYTES_1;
					state_next.sh  = 32'h0000_0000;
					state_next.st  = lfs_pkg::P_HDR;
				end
				lfs_pkg::P_HDR:
				begin
					state_next.sh  = {state_reg.sh[27:0], bus.lad};
					state_next.cnt = state_reg.cnt - 4'h1;
					if (state_reg.cnt == lfs_pkg::HDR_LAST)
					begin
						state_next.hdr = 1'b1;
						state_next.cnt = 4'h0;
						if (state_reg.ct == lfs_pkg::CT_DMA)
							state_next.st = lfs_pkg::P_SIZE;
						else
							state_next.st = state_reg.wr ? lfs_pkg::P_WDATA : lfs_pkg::P_TAR;
					end
				end
				lfs_pkg::P_SIZE:
				begin
					state_next.nb = lfs_pkg::size_bytes(bus.lad[1:0]);
					state_next.st = state_reg.wr ? lfs_pkg::P_WDATA : lfs_pkg::P_TAR;
				end
				lfs_pkg::P_WDATA:
				begin
					state_next.wd[{state_reg.cnt[0], 2'h0} +: 4] = bus.lad;
					state_next.cnt = state_reg.cnt + 4'h1;
					if (state_reg.cnt == lfs_pkg::NIB_LAST)
					begin
						state_next.byt = 1'b1;
						state_next.cnt = 4'h0;
						state_next.st  = lfs_pkg::P_TAR;
					end
				end
				lfs_pkg::P_TAR:
				begin
					state_next.cnt = state_reg.cnt + 4'h1;
					if (state_reg.cnt == lfs_pkg::TAR_LAST)
					begin
						state_next.cnt = wait_in;
						state_next.st  = state_reg.bm ? lfs_pkg::P_BMSYNC : lfs_pkg::P_SYNC;
					end
				end
				lfs_pkg::P_SYNC:
				begin
					if (claim_in && state_reg.cnt != 4'h0)
						state_next.cnt = state_reg.cnt - 4'h1;
					else if (claim_in)
					begin
						state_next.err = err_in;
						state_next.st  = state_reg.wr ? lfs_pkg::P_TARB : lfs_pkg::P_RDATA;
					end
				end
				lfs_pkg::P_RDATA:
				begin
					state_next.cnt = state_reg.cnt + 4'h1;
					if (state_reg.cnt == lfs_pkg::NIB_LAST)
					begin
						state_next.cnt = 4'h0;
						state_next.st  = lfs_pkg::P_TARB;
					end
				end
				lfs_pkg::P_TARB:
				begin
					state_next.cnt = state_reg.cnt + 4'h1;
					if (state_reg.cnt == lfs_pkg::TAR_LAST)
					begin
						state_next.cnt = 4'h0;
						if (!state_reg.err && !last_byte)
						begin
							state_next.bidx = state_reg.bidx + 2'h1;
							state_next.st   = state_reg.wr ? lfs_pkg::P_WDATA : lfs_pkg::P_TAR;
						end
						else
							state_next.st = lfs_pkg::P_IDLE;
					end
				end
				lfs_pkg::P_BMCT: state_next.st = lfs_pkg::P_BMSIZE;
				lfs_pkg::P_BMSIZE:
				begin
					state_next.cnt = 4'h0;
					state_next.st  = lfs_pkg::P_TAR;
				end
				lfs_pkg::P_BMSYNC:
				begin
					if (bus.lad == lfs_pkg::SYNC_READY)
					begin
						state_next.bmdone = 1'b1;
						state_next.st     = lfs_pkg::P_IDLE;
					end
				end
				default: state_next.st = lfs_pkg::P_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign hdr_out     = state_reg.hdr;
	assign ctype_out   = state_reg.ct;
	assign write_out   = state_reg.wr;
	assign addr_out    = state_reg.sh;
	assign byte_out    = state_reg.byt;
	assign wdata_out   = state_reg.wd;
	assign abort_out   = state_reg.abort;
	assign bm_done_out = state_reg.bmdone;
endmodule // lfs_periph

`default_nettype wire

/* rtl/lfs_host.sv */
// Host end: drives cycle fields, decodes bus-master fields and handles SYNC.
`timescale 1ns/1ps
`default_nettype none

module lfs_host (
	input  wire logic        clk_in,
	input  wire logic        arst_n_in,
	lfs_if.host              bus,
	input  wire logic        req_in,
	input  wire logic [1:0]  ctype_in,
	input  wire logic        write_in,
	input  wire logic [1:0]  size_in,
	input  wire logic [2:0]  chan_in,
	input  wire logic [31:0] addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        grant_in,
	input  wire logic        grant_sel_in,
	output logic             ready_out,
	output logic             done_out,
	output logic [1:0]       status_out,
	output logic [31:0]      rdata_out,
	output logic             more_out,
	output logic             syserr_out,
	output logic             bm_out,
	output logic [1:0]       bm_ctype_out,
	output logic             bm_write_out,
	output logic [1:0]       bm_size_out
);
	typedef struct packed {
		lfs_pkg::lfs_hstate_e st;
		logic [3:0]           cnt;
		logic [2:0]           tmo;
		logic [1:0]           bidx;
		logic [2:0]           nbytes;
		logic [1:0]           ct;
		logic                 wr;
		logic [1:0]           sz;
		logic                 bm;
		logic                 sel;
		logic                 err;
		logic [31:0]          sh;
		logic [31:0]          wd;
		logic [31:0]          rd;
		logic                 done;
		logic [1:0]           stat;
		logic                 more;
		logic                 syserr;
	} lfs_hreg_s;

	lfs_hreg_s          state_reg;
	lfs_hreg_s          state_next;
	lfs_pkg::lfs_sync_e sync_kind;
	logic               last_byte;

	lfs_sync_class u_sync_class (
		.lad_in   (bus.lad),
		.dma_in   (state_reg.ct == lfs_pkg::CT_DMA),
		.kind_out (sync_kind)
	);

	assign last_byte = (3'(state_reg.bidx) + 3'h1) >= state_reg.nbytes;

	// ==========================================================================
	// Pin drive
	always_comb
	begin
		bus.lframe_n = 1'b1;
		bus.h_oe_n   = 1'b1;
		bus.h_lad    = lfs_pkg::NIB_ONES;
		unique case (state_reg.st)
			lfs_pkg::H_START:
			begin
				bus.lframe_n = 1'b0;
				bus.h_oe_n   = 1'b0;
				bus.h_lad    = state_reg.bm ? (lfs_pkg::START_BM0 | {3'h0, state_reg.sel})
					: lfs_pkg::START_TGT;
			end
			lfs_pkg::H_CTDIR:
			begin
				bus.h_oe_n = 1'b0;
				bus.h_lad  = lfs_pkg::ctdir_nib(state_reg.ct, state_reg.wr);
			end
			lfs_pkg::H_HDR:
			begin
				bus.h_oe_n = 1'b0;
				bus.h_lad  = state_reg.sh[31:28];
			end
			lfs_pkg::H_SIZE:
			begin
				bus.h_oe_n = 1'b0;
				bus.h_lad  = lfs_pkg::size_nib(state_reg.sz);
			end
			lfs_pkg::H_WDATA:
			begin
				bus.h_oe_n = 1'b0;
				bus.h_lad  = state_reg.wd[lfs_pkg::nib_pos(state_reg.bidx, state_reg.cnt[0]) +: 4];
			end
			lfs_pkg::H_ABORT:
			begin
				// The nibble is released until the last abort clock so that a
				// peripheral still driving SYNC does not fight the host.
				bus.lframe_n = 1'b0;
				if (state_reg.cnt == lfs_pkg::ABORT_LAST)
					bus.h_oe_n = 1'b0;
			end
			lfs_pkg::H_BMSYNC:
			begin
				bus.h_oe_n = 1'b0;
				bus.h_lad  = (state_reg.cnt == lfs_pkg::BM_LWAIT_CLKS) ? lfs_pkg::SYNC_READY
					: lfs_pkg::SYNC_LWAIT;
			end
			default:
			begin
			end
		endcase
	end

	// ==========================================================================
	// Sequencer
	always_comb
	begin
		state_next        = state_reg;
		state_next.done   = 1'b0;
		state_next.syserr = 1'b0;
		unique case (state_reg.st)
			lfs_pkg::H_IDLE:
			begin
				state_next.bidx = 2'h0;
				state_next.cnt  = 4'h0;
				state_next.err  = 1'b0;
				if (req_in && ctype_in != lfs_pkg::CT_RSV)
				begin
					state_next.st   = lfs_pkg::H_START;
					state_next.bm   = 1'b0;
					state_next.ct   = ctype_in;
					state_next.wr   = write_in;
					state_next.more = 1'b0;
					// Only DMA carries a size; size code 10 is never put out.
					state_next.sz = (ctype_in == lfs_pkg::CT_DMA && size_in != lfs_pkg::SZ_RSV)
						? size_in : lfs_pkg::SZ_1;
					state_next.nbytes = lfs_pkg::size_bytes(state_next.sz);
					state_next.wd     = wdata_in;
					state_next.rd     = 32'h0000_0000;
					if (ctype_in == lfs_pkg::CT_DMA)
						state_next.sh = {1'b0, chan_in, 28'h000_0000};
					else if (ctype_in == lfs_pkg::CT_IO)
						state_next.sh = {addr_in[15:0], 16'h0000};
					else
						state_next.sh = addr_in;
				end
				else if (grant_in)
				begin
					state_next.st  = lfs_pkg::H_START;
					state_next.bm  = 1'b1;
					state_next.sel = grant_sel_in;
				end
			end
			lfs_pkg::H_START: state_next.st = state_reg.bm ? lfs_pkg::H_BMCT : lfs_pkg::H_CTDIR;
			lfs_pkg::H_CTDIR:
			begin
				state_next.st  = lfs_pkg::H_HDR;
				state_next.cnt = lfs_pkg::hdr_nibs(state_reg.ct);
			end
			lfs_pkg::H_HDR:
			begin
				state_next.sh  = {state_reg.sh[27:0], 4'h0};
				state_next.cnt = state_reg.cnt - 4'h1;
				if (state_reg.cnt == lfs_pkg::HDR_LAST)
				begin
					state_next.cnt = 4'h0;
					if (state_reg.ct == lfs_pkg::CT_DMA)
						state_next.st = lfs_pkg::H_SIZE;
					else
						state_next.st = state_reg.wr ? lfs_pkg::H_WDATA : lfs_pkg::H_TAR;
				end
			end
			lfs_pkg::H_SIZE: state_next.st = state_reg.wr ? lfs_pkg::H_WDATA : lfs_pkg::H_TAR;
			lfs_pkg::H_WDATA:
			begin
				state_next.cnt = state_reg.cnt + 4'h1;
				if (state_reg.cnt == lfs_pkg::NIB_LAST)
				begin
					state_next.cnt = 4'h0;
					state_next.st  = lfs_pkg::H_TAR;
				end
			end
			lfs_pkg::H_TAR:
			begin
				state_next.cnt = state_reg.cnt + 4'h1;
				state_next.tmo = 3'h0;
				if (state_reg.cnt == lfs_pkg::TAR_LAST)
				begin
					state_next.cnt = 4'h0;
					state_next.st  = state_reg.bm ? lfs_pkg::H_BMSYNC : lfs_pkg::H_SYNC;
				end
			end
			lfs_pkg::H_SYNC:
			begin
				unique case (sync_kind)
					lfs_pkg::SC_READY, lfs_pkg::SC_MORE, lfs_pkg::SC_ERR:
					begin
						state_next.more = (sync_kind == lfs_pkg::SC_MORE);
						if (sync_kind == lfs_pkg::SC_ERR)
						begin
							state_next.err    = 1'b1;
							state_next.syserr = 1'b1;
						end
						state_next.st = state_reg.wr ? lfs_pkg::H_TARB : lfs_pkg::H_RDATA;
					end
					lfs_pkg::SC_SWAIT, lfs_pkg::SC_LWAIT: state_next.tmo = 3'h0;
					lfs_pkg::SC_NONE:
					begin
						state_next.tmo = state_reg.tmo + 3'h1;
						if (state_reg.tmo == lfs_pkg::TIMEOUT_LAST)
							state_next.st = lfs_pkg::H_ABORT;
					end
					default: state_next.st = lfs_pkg::H_ABORT;
				endcase
			end
			lfs_pkg::H_RDATA:
			begin
				state_next.rd[lfs_pkg::nib_pos(state_reg.bidx, state_reg.cnt[0]) +: 4] = bus.lad;
				state_next.cnt = state_reg.cnt + 4'h1;
				if (state_reg.cnt == lfs_pkg::NIB_LAST)
				begin
					state_next.cnt = 4'h0;
					state_next.st  = lfs_pkg::H_TARB;
				end
			end
			lfs_pkg::H_TARB:
			begin
				state_next.cnt = state_reg.cnt + 4'h1;
				if (state_reg.cnt == lfs_pkg::TAR_LAST)
				begin
					state_next.cnt = 4'h0;
					if (!state_reg.bm && !state_reg.err && !last_byte)
					begin
						state_next.bidx = state_reg.bidx + 2'h1;
						state_next.st   = state_reg.wr ? lfs_pkg::H_WDATA : lfs_pkg::H_TAR;
					end
					else
					begin
						state_next.st   = lfs_pkg::H_IDLE;
						state_next.done = 1'b1;
						state_next.stat = state_reg.err ? lfs_pkg::ST_ERR : lfs_pkg::ST_OK;
					end
				end
			end
			lfs_pkg::H_ABORT:
			begin
				state_next.cnt = state_reg.cnt + 4'h1;
				if (state_reg.cnt == lfs_pkg::ABORT_LAST)
				begin
					state_next.st   = lfs_pkg::H_IDLE;
					state_next.done = 1'b1;
					state_next.stat = lfs_pkg::ST_ABORT;
					if (!state_reg.wr && !state_reg.bm)
						state_next.rd = lfs_pkg::RD_ALL_ONES;
				end
			end
			lfs_pkg::H_BMCT:
			begin
				state_next.ct = bus.lad[3:2];
				state_next.wr = bus.lad[1];
				if (bus.lad[3:2] == lfs_pkg::CT_RSV)
					state_next.st = lfs_pkg::H_ABORT;
				else
					state_next.st = lfs_pkg::H_BMSIZE;
			end
			lfs_pkg::H_BMSIZE:
			begin
				state_next.sz = bus.lad[1:0];
				if (bus.lad[1:0] == lfs_pkg::SZ_RSV)
					state_next.st = lfs_pkg::H_ABORT;
				else
					state_next.st = lfs_pkg::H_TAR;
			end
			lfs_pkg::H_BMSYNC:
			begin
				state_next.cnt = state_reg.cnt + 4'h1;
				if (state_reg.cnt == lfs_pkg::BM_LWAIT_CLKS)
				begin
					state_next.cnt = 4'h0;
					state_next.st  = lfs_pkg::H_TARB;
				end
			end
			default: state_next.st = lfs_pkg::H_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign ready_out    = (state_reg.st == lfs_pkg::H_IDLE);
	assign done_out     = state_reg.done;
	assign status_out   = state_reg.stat;
	assign rdata_out    = state_reg.rd;
	assign more_out     = state_reg.more;
	assign syserr_out   = state_reg.syserr;
	assign bm_out       = state_reg.bm;
	assign bm_ctype_out = state_reg.ct;
	assign bm_write_out = state_reg.wr;
	assign bm_size_out  = state_reg.sz;
endmodule // lfs_host

`default_nettype wire

/* verification/lfs_sva.sv */
// Wire-level checks on the LPC link between the host end and the peripheral end.
`timescale 1ns/1ps
`default_nettype none

module lfs_sva (
	input wire logic       clk_in,
	input wire logic       arst_n_in,
	input wire logic       lframe_n,
	input wire logic [3:0] h_lad,
	input wire logic       h_oe_n,
	input wire logic       p_oe_n,
	input wire logic [3:0] lad
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	// A host START of a target cycle has just ended.
	sequence hst;
		$rose(lframe_n) && $past(lad) == 4'h0;
	endsequence

	start_one_a: assert property ($fell(lframe_n) && !h_oe_n |=> lframe_n)
		else $error("start frame too long");
	abort_len_a: assert property ($fell(lframe_n) && h_oe_n |-> !lframe_n[*4] ##1 lframe_n)
		else $error("abort frame length");
	abort_ones_a: assert property ($fell(lframe_n) && h_oe_n |-> ##3 !h_oe_n && h_lad == 4'hF)
		else $error("abort nibble");
	ctdir_lsb_a: assert property (hst |-> !h_oe_n && !h_lad[0] && h_lad[3:2] != 2'h3)
		else $error("cycle type nibble");
	dma_size_a: assert property (hst ##0 lad[3:2] == 2'h2 |-> ##2 !h_oe_n && h_lad[3:2] == 2'h0
		&& h_lad[1:0] != 2'h2)
		else $error("size nibble");
	bm_rsv_a: assert property ($rose(lframe_n) && $past(lad[3:1]) == 3'h1 ##0 lad[3:2] == 2'h3
		|-> ##[1:2] !lframe_n)
		else $error("reserved type not aborted");
	bm_lwait_a: assert property ($rose(lframe_n) && $past(lad[3:1]) == 3'h1 && lad[3:2] != 2'h3
		##1 lad[1:0] != 2'h2 |-> ##3 lad == 4'h6 ##1 lad == 4'h6 ##1 lad == 4'h0)
		else $error("grant wait states");
	to_abort_a: assert property (hst ##0 lad == 4'h0 ##1 p_oe_n[*8] ##1 p_oe_n[*2]
		|-> ##[1:2] !lframe_n)
		else $error("no time-out abort");
	swait_a: assert property (!p_oe_n && lad == 4'h5 |=> lframe_n)
		else $error("short wait aborted");
	bm_ctlsb_a: assert property ($rose(lframe_n) && $past(lad[3:1]) == 3'h1
		|-> !p_oe_n && !lad[0])
		else $error("master cycle type bit");

	c_abort: cover property ($fell(lframe_n) && h_oe_n);
	c_grant: cover property ($rose(lframe_n) && $past(lad) == 4'h2);
	c_swait: cover property ((lad == 4'h5)[*8]);
endmodule // lfs_sva

`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench joining the host end and the peripheral end.
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic        clk_in = 1'b0;
	logic        arst_n_in = 1'b0;
	logic        req_in, write_in, grant_in, grant_sel_in, claim_in, long_wait_in, err_in;
	logic        more_in, bad_sync_in, bm_req_in, bm_sel_in, bm_write_in;
	logic [1:0]  ctype_in, size_in, bm_ctype_in, bm_size_in;
	logic [2:0]  chan_in;
	logic [3:0]  wait_in;
	logic [31:0] addr_in, wdata_in, rdata_in;
	logic        ready_out, done_out, more_out, syserr_out, bm_out, bm_write_out;
	logic        hdr_out, write_out, byte_out, abort_out, bm_done_out;
	logic [1:0]  status_out, bm_ctype_out, bm_size_out, ctype_out;
	logic [31:0] rdata_out, addr_out;
	logic [7:0]  wdata_out;
	int          fails = 0;
	int          total_checks = 0;
	int          nbyte, nerr, nbm, nab, nhdr;

	lfs_if lb ();
	lfs_host lfs_host_i (.clk_in, .arst_n_in, .bus(lb), .req_in, .ctype_in, .write_in,
		.size_in, .chan_in, .addr_in, .wdata_in, .grant_in, .grant_sel_in, .ready_out,
		.done_out, .status_out, .rdata_out, .more_out, .syserr_out, .bm_out, .bm_ctype_out,
		.bm_write_out, .bm_size_out);
	lfs_periph lfs_periph_i (.clk_in, .arst_n_in, .bus(lb), .claim_in, .wait_in,
		.long_wait_in, .err_in, .more_in, .bad_sync_in, .rdata_in, .bm_req_in, .bm_sel_in,
		.bm_ctype_in, .bm_write_in, .bm_size_in, .hdr_out, .ctype_out, .write_out, .addr_out,
		.byte_out, .wdata_out, .abort_out, .bm_done_out);
	lfs_sva lfs_sva_i (.clk_in, .arst_n_in, .lframe_n(lb.lframe_n), .h_lad(lb.h_lad),
		.h_oe_n(lb.h_oe_n), .p_oe_n(lb.p_oe_n), .lad(lb.lad));

	always #2.5 clk_in = ~clk_in;

	// Pulses are counted here because they come and go before done.
	// The falling edge is used so that each pulse is seen after it has settled.
	always @(negedge clk_in)
	begin
		nbyte += int'(byte_out === 1'b1);
		nerr += int'(syserr_out === 1'b1);
		nbm += int'(bm_done_out === 1'b1);
		nab += int'(abort_out === 1'b1);
		nhdr += int'(hdr_out === 1'b1);
	end

	// ==========================================================================
	// Tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic finish_op();
		int n;
		n = 0;
		@(negedge clk_in);
		{req_in, grant_in} = 2'h0;
		while (done_out !== 1'b1 && n < 400)
		begin
			@(negedge clk_in);
			n++;
		end
		if (n >= 400) chk(32'h0, 32'h1, "hang");
		chk(32'(ready_out), 32'h1, "ready");
	endtask

	task automatic host_op(input logic [1:0] ct, input logic wr, input logic [1:0] sz,
		input logic [3:0] wt, input logic cl, input logic er, input logic bad);
		int nb;
		logic [31:0] m;
		logic ab;
		@(negedge clk_in);
		{ctype_in, write_in, size_in, wait_in, long_wait_in} = {ct, wr, sz, wt, wt[0]};
		{claim_in, err_in, bad_sync_in, more_in} = {cl, er, bad, ct == 2'h2 && sz[0]};
		{addr_in, wdata_in, rdata_in, chan_in} = {$urandom, $urandom, $urandom, 3'($urandom)};
		{nbyte, nerr, nab, nhdr} = 128'h0;
		req_in = 1'b1;
		finish_op();
		ab = bad || !cl;
		nb = (ct != 2'h2 || er) ? 1 : (sz == 2'h3 ? 4 : (sz == 2'h1 ? 2 : 1));
		m = (nb == 4) ? 32'hFFFFFFFF : (32'h1 << (8 * nb)) - 32'h1;
		chk(32'(status_out), ab ? 32'h2 : 32'(er), "status");
		if (!wr) chk(rdata_out, ab ? 32'hFFFF_FFFF : rdata_in & m, "rdata");
		if (wr && !ab) chk(32'(nbyte), 32'(nb), "bytes");
		if (wr && !ab) chk(32'(wdata_out), 32'(wdata_in[8 * (nb - 1) +: 8]), "wdata");
		chk(32'(nab), 32'(ab), "abort seen");
		chk(32'(nhdr), 32'h1, "header");
		chk(addr_out, ct == 2'h2 ? 32'(chan_in) : (ct == 2'h0 ? 32'(addr_in[15:0]) : addr_in),
			"addr");
		chk(32'(nerr), 32'(cl && er && !bad), "syserr");
		if (ct == 2'h2 && !ab && !er) chk(32'(more_out), 32'(sz[0]), "more");
		chk(32'({ctype_out, write_out}), 32'({ct, wr}), "type");
	endtask

	task automatic grant_op(input logic [1:0] ct, input logic [1:0] sz);
		logic ok;
		@(negedge clk_in);
		ok = ct != 2'h3 && sz != 2'h2;
		{bm_ctype_in, bm_size_in, bm_write_in, bm_sel_in} = {ct, sz, 2'($urandom)};
		{grant_sel_in, bm_req_in, grant_in} = {bm_sel_in, 2'h3};
		{nbm, nab} = 64'h0;
		finish_op();
		chk(32'(status_out), ok ? 32'h0 : 32'h2, "grant status");
		chk(32'(nab), 32'(!ok), "grant abort");
		chk(32'(nbm), 32'(ok), "grant done");
		if (ok) chk(32'({bm_ctype_out, bm_write_out, bm_size_out}), 32'({ct, bm_write_in, sz}),
			"grant fields");
	endtask

	// ==========================================================================
	// Sequence
	initial
	begin
		{req_in, grant_in, grant_sel_in, bm_req_in, bm_sel_in, bm_write_in} = 6'h0;
		{claim_in, long_wait_in, err_in, more_in, bad_sync_in} = 5'h0;
		{ctype_in, size_in, bm_ctype_in, bm_size_in, chan_in, wait_in} = 15'h0;
		{addr_in, wdata_in, rdata_in} = 96'h0;
		void'($urandom(32'h1F39));
		repeat (5) @(negedge clk_in);
		arst_n_in = 1'b1;
		for (int i = 0; i < 12; i++)
			host_op(2'(i >> 2), i[0], i[2:1], 4'(i), 1'b1, 1'b0, 1'b0);
		host_op(2'h0, 1'b0, 2'h0, 4'hA, 1'b1, 1'b0, 1'b0);
		host_op(2'h2, 1'b0, 2'h3, 4'h1, 1'b1, 1'b1, 1'b0);
		host_op(2'h1, 1'b1, 2'h0, 4'h0, 1'b1, 1'b1, 1'b0);
		host_op(2'h0, 1'b0, 2'h0, 4'h0, 1'b0, 1'b0, 1'b0);
		host_op(2'h2, 1'b1, 2'h1, 4'h0, 1'b1, 1'b0, 1'b1);
		for (int i = 0; i < 16; i++)
			grant_op(2'(i >> 2), i[1:0]);
		stop_test();
	end

	// A generous bound: the whole sequence needs well under a thousand cycles.
	initial
	begin
		#100us;
		fails++;
		stop_test();
	end
endmodule // testbench

`default_nettype wire
